// >>> hw/pcs_sequencer.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer
   import pcs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pcs_cmd_t cmd,
   output logic [PC_W-1:0] pc,
   output logic faultReset
);
   logic rstMeta_q, rstSync_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   wire logic rstN = rstSync_q;

   logic [PC_W-1:0] pc_q, pc_d;
   logic [7:0] latch_q, latch_d;
   logic [4:0] sidx_q, sidx_d;
   logic fre_q, fre_d;
   logic ovf_q, ovf_d, unf_q, unf_d;
   logic fault_q, fault_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q, ready_d, err_q, err_d;
   logic [PC_W-1:0] stack_q [STK_DEPTH];
   logic stkWe;
   logic [3:0] stkWa;
   logic [PC_W-1:0] stkWd;

   wire logic [3:0] topSel = sidx_q[3:0];
   wire logic [PC_W-1:0] topEntry = stack_q[topSel];
   wire logic [PC_W-1:0] pcNext = pc_q + 15'h0001;
   wire logic access = psel && penable && !ready_q;
   wire logic [11:0] regAddr = paddr[13:2];
   // Writes commit at the edge that completes the transfer, when pready is seen high.
   wire logic wrAcc = psel && penable && ready_q && pwrite && pstrb[0];

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == OFS_PC_LOW) || (a == OFS_PCLATCH) || (a == OFS_SIDX) ||
               (a == OFS_TOP_LO) || (a == OFS_TOP_HI) || (a == OFS_CTRL) ||
               (a == OFS_STAT) || (a == OFS_PC_FULL);
   endfunction : mapped

   always_comb begin
      logic isPush;
      logic isPop;
      logic [4:0] pushIdx;
      isPush = 1'b0;
      isPop = 1'b0;
      pushIdx = 5'h00;
      pc_d = pc_q;
      latch_d = latch_q;
      sidx_d = sidx_q;
      fre_d = fre_q;
      ovf_d = ovf_q;
      unf_d = unf_q;
      fault_d = 1'b0;
      stkWe = 1'b0;
      stkWa = 4'h0;
      stkWd = pc_q;
      // Core commands come first; software writes below only touch
      // registers that the command in this cycle leaves alone.
      case (cmd.op)
         OP_NONE: begin
         end
         OP_STEP: pc_d = pcNext;
         OP_WRITE_LOW: pc_d = {latch_q[6:0], cmd.accum};
         OP_ADD_LOW: pc_d = {latch_q[6:0], pc_q[7:0] + cmd.accum};
         OP_CALL_IMM: begin
            pc_d = {latch_q[6:3], cmd.operand};
            isPush = 1'b1;
         end
         OP_CALL_W: begin
            pc_d = {latch_q[6:0], cmd.accum};
            isPush = 1'b1;
         end
         OP_BRANCH_W: pc_d = pcNext + {7'h00, cmd.accum};
         OP_BRANCH_REL: pc_d = pcNext + PC_W'({{4{cmd.operand[10]}}, cmd.operand});
         OP_RETURN, OP_RETURN_LIT, OP_RETURN_INT: isPop = 1'b1;
         OP_IRQ: begin
            pc_d = cmd.vector;
            isPush = 1'b1;
         end
         default: begin
         end
      endcase
      // The pushed value is the return address, the incremented PC.
      if (isPush) begin
         pushIdx = (sidx_q == SIDX_EMPTY) ? 5'h00 : sidx_q + 5'h01;
         if (sidx_q == SIDX_LAST) begin
            ovf_d = 1'b1;
            fault_d = fre_q;
            pushIdx = 5'h00;
         end
         sidx_d = pushIdx;
         stkWe = 1'b1;
         stkWa = pushIdx[3:0];
         stkWd = pcNext;
      end
      if (isPop) begin
         pc_d = topEntry;
         if (sidx_q == SIDX_EMPTY) begin
            unf_d = 1'b1;
            fault_d = fre_q;
            sidx_d = SIDX_LAST;
         end else begin
            sidx_d = sidx_q - 5'h01;
         end
      end
      if (wrAcc) begin
         case (regAddr)
            OFS_PC_LOW: if (cmd.op == OP_NONE) pc_d = {latch_q[6:0], pwdata[7:0]};
            OFS_PCLATCH: latch_d = {1'b0, pwdata[6:0]};
            OFS_SIDX: if (!isPush && !isPop) sidx_d = pwdata[4:0];
            OFS_TOP_LO: if (!isPush) begin
               stkWe = 1'b1;
               stkWa = topSel;
               stkWd = {topEntry[14:8], pwdata[7:0]};
            end
            OFS_TOP_HI: if (!isPush) begin
               stkWe = 1'b1;
               stkWa = topSel;
               stkWd = {pwdata[6:0], topEntry[7:0]};
            end
            OFS_CTRL: fre_d = pwdata[CTRL_FRE_BIT];
            // Software clears flags by writing one; a new fault wins.
            OFS_STAT: begin
               if (pwdata[STAT_OVF_BIT] && !(isPush && sidx_q == SIDX_LAST)) ovf_d = 1'b0;
               if (pwdata[STAT_UNF_BIT] && !(isPop && sidx_q == SIDX_EMPTY)) unf_d = 1'b0;
            end
            default: begin
            end
         endcase
      end
      if (fault_d) begin
         pc_d = '0;
         sidx_d = RST_SIDX;
         latch_d = RST_PCLATCH;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      ready_d = access;
      err_d = access && !mapped(regAddr);
      if (access && !pwrite) begin
         case (regAddr)
            OFS_PC_LOW: rdata_d = {24'h000000, pc_q[7:0]};
            OFS_PCLATCH: rdata_d = {24'h000000, latch_q};
            OFS_SIDX: rdata_d = {27'h0000000, sidx_q};
            OFS_TOP_LO: rdata_d = {24'h000000, topEntry[7:0]};
            OFS_TOP_HI: rdata_d = {25'h0000000, topEntry[14:8]};
            OFS_CTRL: rdata_d = {31'h00000000, fre_q};
            OFS_STAT: rdata_d = {30'h00000000, unf_q, ovf_q};
            OFS_PC_FULL: rdata_d = {17'h00000, pc_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pc_q <= '0;
         latch_q <= RST_PCLATCH;
         sidx_q <= RST_SIDX;
         fre_q <= 1'b0;
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
         fault_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         latch_q <= latch_d;
         sidx_q <= sidx_d;
         fre_q <= fre_d;
         ovf_q <= ovf_d;
         unf_q <= unf_d;
         fault_q <= fault_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
      end
   end

   // Stack entries are not reset; their content is undefined until pushed.
   for (genvar i = 0; i < STK_DEPTH; i++) begin : g_stack
      always_ff @(posedge clk) begin
         if (stkWe && stkWa == 4'(i)) begin
            stack_q[i] <= stkWd;
         end
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;
   assign pc = pc_q;
   assign faultReset = fault_q;

   AST_CALL_TARGET: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_CALL_IMM && !fault_d |=> pc_q == {$past(latch_q[6:3]), $past(cmd.operand)})
      else $error("call target wrong");
   AST_WRITE_LOW: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_WRITE_LOW |=> pc_q == {$past(latch_q[6:0]), $past(cmd.accum)})
      else $error("low write did not load upper bits");
   AST_BRW: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_BRANCH_W |=> pc_q == $past(pc_q) + 15'h0001 + {7'h00, $past(cmd.accum)})
      else $error("branch w target wrong");
   AST_STEP: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_STEP |=> pc_q == $past(pc_q) + 15'h0001)
      else $error("step did not add one");
   AST_ADD_NO_CARRY: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_ADD_LOW |=> pc_q[14:8] == $past(latch_q[6:0]))
      else $error("add carried into upper bits");
   AST_LATCH_KEEP: assert property (@(posedge clk) disable iff (!rstN)
      (cmd.op inside {OP_CALL_IMM, OP_CALL_W, OP_RETURN, OP_IRQ}) && !wrAcc && !fault_d
      |=> $stable(latch_q))
      else $error("latch changed by stack action");
   sequence s_callPush;
      cmd.op inside {OP_CALL_IMM, OP_CALL_W, OP_IRQ} && sidx_q != SIDX_LAST;
   endsequence
   AST_PUSH_ORDER: assert property (@(posedge clk) disable iff (!rstN)
      s_callPush |=> sidx_q == $past(sidx_q) + 5'h01
      ##0 stack_q[sidx_q[3:0]] == $past(pc_q) + 15'h0001)
      else $error("push order wrong");
   wire logic isPushLast = (cmd.op inside {OP_CALL_IMM, OP_CALL_W, OP_IRQ})
      && sidx_q == SIDX_LAST;
   wire logic isPopOp = cmd.op inside {OP_RETURN, OP_RETURN_LIT, OP_RETURN_INT};
   AST_OVF_FLAG: assert property (@(posedge clk) disable iff (!rstN)
      isPushLast |=> ovf_q && sidx_q == ($past(fre_q) ? RST_SIDX : 5'h00))
      else $error("overflow not flagged");
   AST_UNF_RESET: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_RETURN && sidx_q == SIDX_EMPTY && fre_q |=> unf_q && pc_q == 15'h0000)
      else $error("underflow reset missing");
   AST_CALL_W_A_TARGET: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_CALL_W && !fault_d |=> pc_q == {$past(latch_q[6:0]), $past(cmd.accum)})
      else $error("computed call target wrong");
   AST_BRANCH_REL: assert property (@(posedge clk) disable iff (!rstN)
      cmd.op == OP_BRANCH_REL |=> pc_q == $past(pc_q) + 15'h0001
      + {{4{$past(cmd.operand[10])}}, $past(cmd.operand)})
      else $error("relative branch target wrong");
   // A pop that finds entries must hand back the selected entry before stepping down.
   sequence s_plainPop;
      isPopOp && sidx_q != SIDX_EMPTY;
   endsequence
   AST_POP_TOP: assert property (@(posedge clk) disable iff (!rstN)
      s_plainPop |=> pc_q == $past(topEntry) ##0 sidx_q == $past(sidx_q) - 5'h01)
      else $error("pop returned wrong entry");
   AST_EMPTY_AFTER_LAST: assert property (@(posedge clk) disable iff (!rstN)
      isPopOp && sidx_q == 5'h00 |=> sidx_q == SIDX_EMPTY)
      else $error("stack not empty after last pop");
   AST_UNF_WRAP: assert property (@(posedge clk) disable iff (!rstN)
      isPopOp && sidx_q == SIDX_EMPTY && !fre_q |=> unf_q && sidx_q == SIDX_LAST)
      else $error("underflow did not wrap");
   AST_FAULT_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
      fault_d |=> faultReset && pc_q == 15'h0000 && latch_q == RST_PCLATCH
      && sidx_q == RST_SIDX)
      else $error("fault reset incomplete");
   AST_LATCH_WRITE: assert property (@(posedge clk) disable iff (!rstN)
      wrAcc && regAddr == OFS_PCLATCH && !fault_d |=> latch_q == {1'b0, $past(pwdata[6:0])})
      else $error("latch write lost");
   AST_TOP_WRITE: assert property (@(posedge clk) disable iff (!rstN)
      wrAcc && regAddr == OFS_TOP_LO && cmd.op == OP_NONE
      |=> topEntry[7:0] == $past(pwdata[7:0]))
      else $error("top entry write lost");
endmodule : pcs_sequencer
`default_nettype wire

// >>> hw/pcs_pkg.sv
package pcs_pkg;
   localparam int PC_W = 15;
   localparam int SP_W = 5;
   localparam int STK_DEPTH = 16;
   localparam logic [11:0] OFS_PC_LOW = 12'hf82;
   localparam logic [11:0] OFS_PCLATCH = 12'hf8a;
   localparam logic [11:0] OFS_SIDX = 12'hfed;
   localparam logic [11:0] OFS_TOP_LO = 12'hfee;
   localparam logic [11:0] OFS_TOP_HI = 12'hfef;
   localparam logic [11:0] OFS_CTRL = 12'hff0;
   localparam logic [11:0] OFS_STAT = 12'hff1;
   localparam logic [11:0] OFS_PC_FULL = 12'hff2;
   localparam logic [7:0] RST_PCLATCH = 8'h00;
   localparam logic [4:0] RST_SIDX = 5'h1f;
   localparam logic [4:0] SIDX_EMPTY = 5'h1f;
   localparam logic [4:0] SIDX_LAST = 5'h0f;
   localparam int CTRL_FRE_BIT = 0;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_UNF_BIT = 1;

   typedef enum logic [3:0] {
      OP_NONE, OP_STEP, OP_WRITE_LOW, OP_ADD_LOW, OP_CALL_IMM, OP_CALL_W,
      OP_BRANCH_W, OP_BRANCH_REL, OP_RETURN, OP_RETURN_LIT, OP_RETURN_INT, OP_IRQ
   } pcs_op_t;

   typedef struct packed {
      pcs_op_t op;
      logic [10:0] operand;
      logic [7:0] accum;
      logic [PC_W-1:0] vector;
   } pcs_cmd_t;
endpackage : pcs_pkg

// >>> testbench/pcs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Like the real decoder, it holds each operation for exactly one cycle and then goes idle.
module pcs_core_model
   import pcs_pkg::*;
(
   input wire logic clk,
   output pcs_cmd_t cmd
);
   initial cmd = '0;
   task automatic issue(input pcs_op_t o, input logic [10:0] opd, input logic [7:0] acc);
      @(posedge clk);
      cmd <= '{op: o, operand: opd, accum: acc, vector: 15'h0004};
      @(posedge clk);
      cmd <= '0;
   endtask : issue
endmodule : pcs_core_model
`default_nettype wire

// >>> testbench/tb_program_counter_and_return_stack.sv
`timescale 1ns/1ps
`default_nettype none
module tb_program_counter_and_return_stack
   import pcs_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [PC_W-1:0] pc;
   logic faultReset;
   pcs_cmd_t cmd;
   logic [31:0] rdv;
   logic errv;
   logic seen;
   int fail_count = 0;
   int checks = 0;

   initial begin
      forever #4 clk = ~clk;
   end

   pcs_core_model pcs_core_model_inst (.clk(clk), .cmd(cmd));
   pcs_sequencer pcs_sequencer_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd), .pc(pc),
      .faultReset(faultReset));

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   // The answer is taken at the rising edge where pready is sampled high, then released.
   task automatic xfer(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {18'h0, ofs, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         fail_count++;
         tally_and_finish();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
      xfer(1'b0, ofs, 32'h0);
      chk(rdv, exp);
   endtask : rd

   task automatic op(input pcs_op_t o, input logic [10:0] opd, input logic [7:0] acc,
                     input logic [14:0] exp);
      pcs_core_model_inst.issue(o, opd, acc);
      #1;
      chk({17'h0, pc}, {17'h0, exp});
   endtask : op

   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk({17'h0, pc}, 32'h0);
      rd(OFS_PCLATCH, 32'h0);
      rd(OFS_SIDX, 32'h1f);
      xfer(1'b0, 12'h000, 32'h0);
      chk({31'h0, errv}, 32'h1);
      $display("reset and map test done");
      xfer(1'b1, OFS_PCLATCH, 32'h12);
      xfer(1'b1, OFS_PC_LOW, 32'h34);
      rd(OFS_PC_FULL, 32'h1234);
      rd(OFS_PC_LOW, 32'h34);
      op(OP_STEP, 11'h0, 8'h0, 15'h1235);
      op(OP_CALL_IMM, 11'h567, 8'h0, 15'h1567);
      rd(OFS_SIDX, 32'h0);
      rd(OFS_TOP_LO, 32'h36);
      rd(OFS_TOP_HI, 32'h12);
      op(OP_CALL_W, 11'h0, 8'hab, 15'h12ab);
      op(OP_IRQ, 11'h0, 8'h0, 15'h0004);
      op(OP_RETURN_INT, 11'h0, 8'h0, 15'h12ac);
      op(OP_RETURN, 11'h0, 8'h0, 15'h1568);
      op(OP_RETURN_LIT, 11'h0, 8'h0, 15'h1236);
      rd(OFS_SIDX, 32'h1f);
      rd(OFS_PCLATCH, 32'h12);
      xfer(1'b1, OFS_PC_LOW, 32'hfe);
      op(OP_BRANCH_W, 11'h0, 8'h05, 15'h1304);
      op(OP_BRANCH_REL, 11'h7fe, 8'h0, 15'h1303);
      op(OP_ADD_LOW, 11'h0, 8'hff, 15'h1202);
      op(OP_WRITE_LOW, 11'h0, 8'h40, 15'h1240);
      $display("program counter test done");
      for (int k = 0; k < 16; k++) begin
         op(OP_IRQ, 11'h0, 8'h0, 15'h0004);
      end
      rd(OFS_SIDX, 32'h0f);
      rd(OFS_STAT, 32'h0);
      op(OP_IRQ, 11'h0, 8'h0, 15'h0004);
      rd(OFS_SIDX, 32'h0);
      rd(OFS_TOP_LO, 32'h05);
      rd(OFS_STAT, 32'h1);
      xfer(1'b1, OFS_STAT, 32'h1);
      xfer(1'b1, OFS_TOP_LO, 32'h77);
      xfer(1'b1, OFS_TOP_HI, 32'h2a);
      rd(OFS_TOP_HI, 32'h2a);
      rd(OFS_TOP_LO, 32'h77);
      op(OP_RETURN, 11'h0, 8'h0, 15'h2a77);
      rd(OFS_SIDX, 32'h1f);
      op(OP_RETURN, 11'h0, 8'h0, 15'h0005);
      rd(OFS_SIDX, 32'h0f);
      rd(OFS_STAT, 32'h2);
      $display("stack wrap test done");
      xfer(1'b1, OFS_STAT, 32'h3);
      xfer(1'b1, OFS_CTRL, 32'h1);
      xfer(1'b1, OFS_SIDX, 32'h1f);
      pcs_core_model_inst.issue(OP_RETURN, 11'h0, 8'h0);
      seen = 1'b0;
      repeat (4) begin
         @(negedge clk);
         seen = seen | (faultReset === 1'b1);
      end
      chk({31'h0, seen}, 32'h1);
      rd(OFS_PC_FULL, 32'h0);
      rd(OFS_STAT, 32'h2);
      rd(OFS_PCLATCH, 32'h0);
      $display("fault reset test done");
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end
endmodule : tb_program_counter_and_return_stack
`default_nettype wire
